// ==== pdma_engine.sv ====
// Instruction engine, queues, cache and data buffer of the DMA controller
`timescale 1ns/1ps
module pdma_fifo
  import pdma_pkg::*;
#(
  parameter int WIDTH = 72,
  parameter int DEPTH = 16
) (
  input  wire logic             i_ref_clk,
  input  wire logic             i_reset,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic      [WIDTH-1:0] o_out_data
);
  localparam int AW = $clog2(DEPTH);
  if (DEPTH < 2 || (1 << AW) != DEPTH)
  begin : g_bad_depth
    $error("pdma_fifo depth must be a power of two");
  end
  logic [WIDTH-1:0] mem_reg  [DEPTH];
  logic [WIDTH-1:0] mem_next [DEPTH];
  logic [AW-1:0]    wr_reg;
  logic [AW-1:0]    wr_next;
  logic [AW-1:0]    rd_reg;
  logic [AW-1:0]    rd_next;
  logic [AW:0]      cnt_reg;
  logic [AW:0]      cnt_next;
  logic             push;
  logic             pop;

  assign o_in_ready  = cnt_reg != (AW+1)'(DEPTH);
  assign o_out_valid = cnt_reg != '0;
  assign o_out_data  = mem_reg[rd_reg];

  always_comb
  begin
    push     = i_in_valid && o_in_ready;
    pop      = o_out_valid && i_out_ready;
    mem_next = mem_reg;
    if (push)
    begin
      mem_next[wr_reg] = i_in_data;
    end
    wr_next  = push ? wr_reg + 1'b1 : wr_reg;
    rd_next  = pop ? rd_reg + 1'b1 : rd_reg;
    cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge i_ref_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      mem_reg <= '{default: '0};
      wr_reg  <= '0;
      rd_reg  <= '0;
      cnt_reg <= '0;
    end
    else
    begin
      mem_reg <= mem_next;
      wr_reg  <= wr_next;
      rd_reg  <= rd_next;
      cnt_reg <= cnt_next;
    end
  end
endmodule

module pdma_engine
  import pdma_pkg::*;
(
  input  wire logic                         i_ref_clk,
  input  wire logic                         i_reset,
  input  wire pdma_inject_t                 i_inject_sec,
  output logic                              o_inject_sec_ready,
  input  wire pdma_inject_t                 i_inject_nsec,
  output logic                              o_inject_nsec_ready,
  output pdma_axi_m_t                       o_axi,
  input  wire pdma_axi_s_t                  i_axi,
  input  wire pdma_req_t [NUM_PERIPH-1:0]   i_req,
  output logic           [NUM_PERIPH-1:0]   o_req_ready,
  output pdma_ack_t      [NUM_PERIPH-1:0]   o_ack,
  input  wire logic      [NUM_PERIPH-1:0]   i_ack_ready,
  input  wire logic      [NUM_CHAN-1:0]     i_event_clear,
  input  wire logic                         i_abort_clear,
  input  wire logic      [1:0]              i_ecc_clear,
  input  wire logic      [1:0]              i_ecc_flip,
  output logic                              o_irq_abort,
  output logic           [NUM_CHAN-1:0]     o_irq_event,
  output logic                              o_irq_ecc_single,
  output logic                              o_irq_ecc_double,
  output logic           [NUM_CHAN-1:0]     o_chan_active,
  output logic                              o_pipe_stall
);
  logic [LINE_BITS-1:0] line_reg [16];
  logic [LINE_BITS-1:0] line_next [16];
  logic [TAG_W-1:0]     tag_reg [16];
  logic [TAG_W-1:0]     tag_next [16];
  logic [15:0]          lvalid_reg, lvalid_next;
  pdma_fill_t           fill_reg, fill_next;
  logic [31:0]          faddr_reg, faddr_next;
  logic [1:0]           beat_reg, beat_next;
  logic [31:0]          pc_reg [NUM_CHAN];
  logic [31:0]          pc_next [NUM_CHAN];
  logic [31:0]          sar_reg [NUM_CHAN];
  logic [31:0]          sar_next [NUM_CHAN];
  logic [31:0]          dar_reg [NUM_CHAN];
  logic [31:0]          dar_next [NUM_CHAN];
  logic [NUM_CHAN-1:0]  act_reg, act_next;
  logic [NUM_CHAN-1:0]  evt_reg, evt_next;
  logic [2:0]           rr_reg, rr_next;
  logic                 slot_reg, slot_next;
  logic                 stall_reg, stall_next;
  logic                 abort_reg, abort_next;
  logic [2:0]           pcnt_reg [NUM_PERIPH];
  logic [2:0]           pcnt_next [NUM_PERIPH];
  pdma_ack_t [NUM_PERIPH-1:0] ack_reg, ack_next;
  logic [3:0]           rdo_reg, rdo_next, wro_reg, wro_next;
  logic                 awd_reg, awd_next, wd_reg, wd_next;
  logic                 arq_hold_reg, arq_hold_next;
  logic                 ecc1_reg, ecc1_next, ecc2_reg, ecc2_next;
  logic                 fill_start, fill_done, ar_fill, ar_fire;
  logic                 aw_fire, w_fire, b_fire;
  logic [31:0]          miss_addr;
  logic                 rdq_push, rdq_in_rdy, rdq_vld, rdq_pop;
  logic                 wrq_push, wrq_in_rdy, wrq_vld, wrq_pop;
  pdma_xfer_t           xfer_in, rdq_out, wrq_out;
  logic                 buf_push, buf_in_rdy, buf_vld;
  logic [71:0]          buf_out;
  logic [7:0]           syn;

  function automatic logic [7:0] byte_at(input logic [31:0] a);
    return line_reg[a[8:5]][a[4:0]*8 +: 8];
  endfunction

  function automatic logic hit(input logic [31:0] a);
    return lvalid_reg[a[8:5]] && tag_reg[a[8:5]] == a[31:TAG_LSB];
  endfunction

  function automatic logic [2:0] insn_len(input logic [7:0] op);
    case (op)
      OP_GO, OP_MOV:          return 3'h6;
      OP_WFP, OP_SEV, OP_ACKP: return 3'h2;
      default:                return 3'h1;
    endcase
  endfunction

  // Hamming column {1,i} per data bit plus overall parity
  function automatic logic [7:0] ecc_gen(input logic [63:0] d);
    logic [7:0] p;
    p = '0;
    for (int i = 0; i < 64; i++)
    begin
      if (d[i])
      begin
        p[6:0] = p[6:0] ^ {1'b1, 6'(i)};
      end
    end
    p[7] = ^{d, p[6:0]};
    return p;
  endfunction

  pdma_fifo #(.WIDTH(35), .DEPTH(QUEUE_DEPTH)) u_rdq (
    .i_ref_clk   (i_ref_clk),
    .i_reset     (i_reset),
    .i_in_valid  (rdq_push),
    .o_in_ready  (rdq_in_rdy),
    .i_in_data   (xfer_in),
    .o_out_valid (rdq_vld),
    .i_out_ready (rdq_pop),
    .o_out_data  (rdq_out)
  );
  pdma_fifo #(.WIDTH(35), .DEPTH(QUEUE_DEPTH)) u_wrq (
    .i_ref_clk   (i_ref_clk),
    .i_reset     (i_reset),
    .i_in_valid  (wrq_push),
    .o_in_ready  (wrq_in_rdy),
    .i_in_data   (xfer_in),
    .o_out_valid (wrq_vld),
    .i_out_ready (wrq_pop),
    .o_out_data  (wrq_out)
  );
  pdma_fifo #(.WIDTH(72), .DEPTH(BUF_DEPTH)) u_buf (
    .i_ref_clk   (i_ref_clk),
    .i_reset     (i_reset),
    .i_in_valid  (buf_push),
    .o_in_ready  (buf_in_rdy),
    .i_in_data   ({ecc_gen(i_axi.rdata), i_axi.rdata ^ {62'h0, i_ecc_flip}}),
    .o_out_valid (buf_vld),
    .i_out_ready (w_fire),
    .o_out_data  (buf_out)
  );

  // Thread scheduling and execution
  always_comb
  begin
    logic [2:0]  sel;
    logic [2:0]  c;
    logic        have, run, mgr, done, bad, src_sec;
    logic [31:0] pc, imm;
    logic [2:0]  len;
    logic [47:0] insn;
    logic [4:0]  p;
    sel = rr_reg;
    c = '0;
    have = 1'b0;
    run = 1'b0;
    mgr = 1'b0;
    done = 1'b0;
    bad = 1'b0;
    src_sec = 1'b0;
    insn = '0;
    pc = '0;
    imm = '0;
    len = '0;
    p = '0;
    act_next = act_reg;
    pc_next = pc_reg;
    sar_next = sar_reg;
    dar_next = dar_reg;
    rr_next = rr_reg;
    slot_next = ~slot_reg;
    pcnt_next = pcnt_reg;
    ack_next = ack_reg;
    evt_next = evt_reg & ~i_event_clear;
    abort_next = abort_reg & ~i_abort_clear;
    rdq_push = 1'b0;
    wrq_push = 1'b0;
    xfer_in = '0;
    fill_start = 1'b0;
    stall_next = stall_reg;
    for (int k = 1; k <= NUM_CHAN; k++)
    begin
      c = rr_reg + 3'(k);
      if (!have && act_reg[c])
      begin
        have = 1'b1;
        sel = c;
      end
    end
    pc = pc_reg[sel];
    len = insn_len(byte_at(pc));
    miss_addr = hit(pc) ? pc + 32'(len) - 32'h1 : pc;
    if (!stall_reg)
    begin
      if (!slot_reg)
      begin
        mgr = 1'b1;
        src_sec = i_inject_sec.valid;
        run = i_inject_sec.valid || i_inject_nsec.valid;
        insn = src_sec ? i_inject_sec.insn : i_inject_nsec.insn;
      end
      else if (have)
      begin
        rr_next = sel;
        if (hit(pc) && hit(pc + 32'(len) - 32'h1))
        begin
          run = 1'b1;
          for (int k = 0; k < 6; k++)
          begin
            insn[k*8 +: 8] = byte_at(pc + 32'(k));
          end
        end
        else if (fill_reg == FILL_IDLE)
        begin
          fill_start = 1'b1;
        end
        else if (miss_addr[31:IDX_LSB] != faddr_reg[31:IDX_LSB])
        begin
          stall_next = 1'b1;
        end
      end
    end
    if (fill_done)
    begin
      stall_next = 1'b0;
    end
    p = insn[12:8];
    imm = insn[47:16];
    // Single instruction per cycle, from the current slot only
    if (run)
    begin
      case (insn[7:0])
        OP_END:
        begin
          done = 1'b1;
          if (!mgr)
          begin
            act_next[sel] = 1'b0;
          end
        end
        OP_NOP: done = 1'b1;
        OP_LD, OP_ST:
        begin
          xfer_in = {sel, insn[7:0] == OP_LD ? sar_reg[sel] : dar_reg[sel]};
          if (mgr)
          begin
            bad = 1'b1;
          end
          else if (insn[7:0] == OP_LD && rdq_in_rdy)
          begin
            rdq_push = 1'b1;
            sar_next[sel] = sar_reg[sel] + ADDR_STEP;
            done = 1'b1;
          end
          else if (insn[7:0] == OP_ST && wrq_in_rdy)
          begin
            wrq_push = 1'b1;
            dar_next[sel] = dar_reg[sel] + ADDR_STEP;
            done = 1'b1;
          end
        end
        OP_WFP:
        begin
          if (mgr || p == 5'h1F)
          begin
            bad = 1'b1;
          end
          else if (pcnt_reg[p] != '0)
          begin
            pcnt_next[p] = pcnt_reg[p] - 3'h1;
            done = 1'b1;
          end
        end
        OP_ACKP:
        begin
          if (mgr || p == 5'h1F)
          begin
            bad = 1'b1;
          end
          else if (!ack_reg[p].valid)
          begin
            ack_next[p] = {1'b1, insn[14:13]};
            done = 1'b1;
          end
        end
        OP_SEV:
        begin
          evt_next[insn[10:8]] = 1'b1;
          done = 1'b1;
        end
        OP_MOV:
        begin
          bad = mgr;
          done = 1'b1;
          if (!mgr && insn[8])
          begin
            dar_next[sel] = imm;
          end
          else if (!mgr)
          begin
            sar_next[sel] = imm;
          end
        end
        OP_GO:
        begin
          bad = !mgr;
          done = 1'b1;
          if (mgr)
          begin
            act_next[insn[10:8]] = 1'b1;
            pc_next[insn[10:8]] = imm;
          end
        end
        default: bad = 1'b1;
      endcase
    end
    if (bad)
    begin
      abort_next = 1'b1;
      done = 1'b1;
      if (!mgr)
      begin
        act_next[sel] = 1'b0;
      end
    end
    if (done && !mgr && !bad && insn[7:0] != OP_END)
    begin
      pc_next[sel] = pc + 32'(len);
    end
    o_inject_sec_ready = done && mgr && src_sec;
    o_inject_nsec_ready = done && mgr && !src_sec;
    for (int i = 0; i < NUM_PERIPH; i++)
    begin
      o_req_ready[i] = pcnt_reg[i] < PERIPH_MAX_OUT;
      if (i_req[i].valid && o_req_ready[i])
      begin
        pcnt_next[i] = i_req[i].kind == KIND_FLUSH ? 3'h0 : pcnt_next[i] + 3'h1;
      end
      if (ack_reg[i].valid && i_ack_ready[i])
      begin
        ack_next[i].valid = 1'b0;
      end
    end
  end

  // Cache line fill over the shared master
  always_comb
  begin
    line_next = line_reg;
    tag_next = tag_reg;
    lvalid_next = lvalid_reg;
    fill_next = fill_reg;
    faddr_next = faddr_reg;
    beat_next = beat_reg;
    case (fill_reg)
      FILL_IDLE:
      begin
        if (fill_start)
        begin
          faddr_next = {miss_addr[31:IDX_LSB], 5'h00};
          lvalid_next[miss_addr[8:5]] = 1'b0;
          fill_next = FILL_ADDR;
        end
      end
      FILL_ADDR:
      begin
        beat_next = 2'h0;
        if (ar_fire && ar_fill)
        begin
          fill_next = FILL_DATA;
        end
      end
      FILL_DATA:
      begin
        if (i_axi.rvalid && i_axi.rid == FILL_ID)
        begin
          line_next[faddr_reg[8:5]][beat_reg*64 +: 64] = i_axi.rdata;
          beat_next = beat_reg + 2'h1;
          if (fill_done)
          begin
            lvalid_next[faddr_reg[8:5]] = 1'b1;
            tag_next[faddr_reg[8:5]] = faddr_reg[31:TAG_LSB];
            fill_next = FILL_IDLE;
          end
        end
      end
      default: fill_next = FILL_IDLE;
    endcase
  end

  // AXI master, outstanding counts and ECC check
  always_comb
  begin
    ar_fill = fill_reg == FILL_ADDR && !arq_hold_reg;
    o_axi = '0;
    o_axi.arvalid = rdo_reg < MAX_RD_OUT && (ar_fill || rdq_vld);
    o_axi.araddr = ar_fill ? faddr_reg : rdq_out.addr;
    o_axi.arid = ar_fill ? FILL_ID : {1'b0, rdq_out.chan};
    o_axi.arlen = ar_fill ? FILL_LEN : 8'h00;
    o_axi.arsize = AXI_SIZE_8;
    o_axi.arburst = AXI_INCR;
    o_axi.rready = i_axi.rid == FILL_ID || buf_in_rdy;
    o_axi.awvalid = wrq_vld && !awd_reg && wro_reg < MAX_WR_OUT;
    o_axi.awaddr = wrq_out.addr;
    o_axi.awid = {1'b0, wrq_out.chan};
    o_axi.awsize = AXI_SIZE_8;
    o_axi.awburst = AXI_INCR;
    o_axi.wvalid = wrq_vld && buf_vld && !wd_reg;
    o_axi.wdata = buf_out[63:0];
    o_axi.wstrb = 8'hFF;
    o_axi.wlast = 1'b1;
    o_axi.bready = 1'b1;
    ar_fire = o_axi.arvalid && i_axi.arready;
    rdq_pop = ar_fire && !ar_fill;
    arq_hold_next = o_axi.arvalid && !i_axi.arready && !ar_fill;
    fill_done = i_axi.rvalid && i_axi.rid == FILL_ID && i_axi.rlast;
    buf_push = i_axi.rvalid && i_axi.rid != FILL_ID;
    aw_fire = o_axi.awvalid && i_axi.awready;
    w_fire = o_axi.wvalid && i_axi.wready;
    b_fire = i_axi.bvalid;
    wrq_pop = (awd_reg || aw_fire) && (wd_reg || w_fire);
    awd_next = wrq_pop ? 1'b0 : awd_reg || aw_fire;
    wd_next = wrq_pop ? 1'b0 : wd_reg || w_fire;
    rdo_next = rdo_reg + 4'(ar_fire)
             - 4'(i_axi.rvalid && o_axi.rready && i_axi.rlast);
    wro_next = wro_reg + 4'(aw_fire) - 4'(b_fire);
    syn = ecc_gen(buf_out[63:0]) ^ buf_out[71:64];
    syn[7] = ^buf_out;
    ecc1_next = ecc1_reg && !i_ecc_clear[0];
    ecc2_next = ecc2_reg && !i_ecc_clear[1];
    if (w_fire && syn[7])
    begin
      ecc1_next = 1'b1;
    end
    if (w_fire && !syn[7] && syn[6:0] != '0)
    begin
      ecc2_next = 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_reset)
  begin
    if (i_reset)
    begin
      line_reg <= '{default: '0};
      tag_reg <= '{default: '0};
      lvalid_reg <= '0;
      fill_reg <= FILL_IDLE;
      faddr_reg <= '0;
      beat_reg <= '0;
      pc_reg <= '{default: '0};
      sar_reg <= '{default: '0};
      dar_reg <= '{default: '0};
      act_reg <= '0;
      evt_reg <= '0;
      rr_reg <= 3'h7;
      slot_reg <= 1'b0;
      stall_reg <= 1'b0;
      abort_reg <= 1'b0;
      pcnt_reg <= '{default: '0};
      ack_reg <= '0;
      rdo_reg <= '0;
      wro_reg <= '0;
      awd_reg <= 1'b0;
      wd_reg <= 1'b0;
      arq_hold_reg <= 1'b0;
      ecc1_reg <= 1'b0;
      ecc2_reg <= 1'b0;
    end
    else
    begin
      line_reg <= line_next;
      tag_reg <= tag_next;
      lvalid_reg <= lvalid_next;
      fill_reg <= fill_next;
      faddr_reg <= faddr_next;
      beat_reg <= beat_next;
      pc_reg <= pc_next;
      sar_reg <= sar_next;
      dar_reg <= dar_next;
      act_reg <= act_next;
      evt_reg <= evt_next;
      rr_reg <= rr_next;
      slot_reg <= slot_next;
      stall_reg <= stall_next;
      abort_reg <= abort_next;
      pcnt_reg <= pcnt_next;
      ack_reg <= ack_next;
      rdo_reg <= rdo_next;
      wro_reg <= wro_next;
      awd_reg <= awd_next;
      wd_reg <= wd_next;
      arq_hold_reg <= arq_hold_next;
      ecc1_reg <= ecc1_next;
      ecc2_reg <= ecc2_next;
    end
  end

  assign o_ack = ack_reg;
  assign o_irq_abort = abort_reg;
  assign o_irq_event = evt_reg;
  assign o_irq_ecc_single = ecc1_reg;
  assign o_irq_ecc_double = ecc2_reg;
  assign o_chan_active = act_reg;
  assign o_pipe_stall = stall_reg;
endmodule

// ==== pdma_pkg.sv ====
// Shared constants and types of the program-driven DMA controller
package pdma_pkg;
  localparam int NUM_CHAN    = 8;
  localparam int NUM_PERIPH  = 31;
  localparam int QUEUE_DEPTH = 16;
  localparam int BUF_DEPTH   = 16;
  localparam int LINE_BITS   = 256;
  localparam int IDX_LSB     = 5;
  localparam int TAG_LSB     = 9;
  localparam int TAG_W       = 23;
  localparam logic [3:0] MAX_RD_OUT = 4'h8;
  localparam logic [3:0] MAX_WR_OUT = 4'h8;
  localparam logic [2:0] PERIPH_MAX_OUT = 3'h4;
  localparam logic [7:0] OP_END  = 8'h00;
  localparam logic [7:0] OP_NOP  = 8'h01;
  localparam logic [7:0] OP_LD   = 8'h04;
  localparam logic [7:0] OP_ST   = 8'h08;
  localparam logic [7:0] OP_WFP  = 8'h30;
  localparam logic [7:0] OP_SEV  = 8'h34;
  localparam logic [7:0] OP_ACKP = 8'h38;
  localparam logic [7:0] OP_GO   = 8'hA0;
  localparam logic [7:0] OP_MOV  = 8'hBC;
  localparam logic [1:0] KIND_SINGLE = 2'h0;
  localparam logic [1:0] KIND_BURST  = 2'h1;
  localparam logic [1:0] KIND_FLUSH  = 2'h2;
  localparam logic [3:0] FILL_ID     = 4'hF;
  localparam logic [7:0] FILL_LEN    = 8'h03;
  localparam logic [2:0] AXI_SIZE_8  = 3'h3;
  localparam logic [1:0] AXI_INCR    = 2'h1;
  localparam logic [31:0] ADDR_STEP  = 32'h0000_0008;
  typedef struct packed {logic valid; logic [1:0] kind; logic last;} pdma_req_t;
  typedef struct packed {logic valid; logic [1:0] kind;} pdma_ack_t;
  typedef struct packed {logic valid; logic [47:0] insn;} pdma_inject_t;
  typedef struct packed {logic [2:0] chan; logic [31:0] addr;} pdma_xfer_t;
  typedef struct packed {
    logic arvalid; logic [31:0] araddr; logic [3:0] arid; logic [7:0] arlen;
    logic [2:0] arsize; logic [1:0] arburst; logic rready;
    logic awvalid; logic [31:0] awaddr; logic [3:0] awid; logic [7:0] awlen;
    logic [2:0] awsize; logic [1:0] awburst;
    logic wvalid; logic [63:0] wdata; logic [7:0] wstrb; logic wlast; logic bready;
  } pdma_axi_m_t;
  typedef struct packed {
    logic arready; logic rvalid; logic [63:0] rdata; logic [3:0] rid;
    logic [1:0] rresp; logic rlast; logic awready; logic wready;
    logic bvalid; logic [3:0] bid; logic [1:0] bresp;
  } pdma_axi_s_t;
  typedef enum logic [1:0] {
    FILL_IDLE = 2'b00,
    FILL_ADDR = 2'b01,
    FILL_DATA = 2'b10
  } pdma_fill_t;
endpackage

// ==== pdma_checker.sv ====
// Port checker for the DMA instruction engine
`timescale 1ns/1ps
module pdma_checker
  import pdma_pkg::*;
(
  input  wire logic                       i_ref_clk,
  input  wire logic                       i_reset,
  input  wire pdma_inject_t               i_inject_sec,
  input  wire logic                       o_inject_sec_ready,
  input  wire logic                       o_inject_nsec_ready,
  input  wire pdma_axi_m_t                o_axi,
  input  wire pdma_axi_s_t                i_axi,
  input  wire pdma_req_t [NUM_PERIPH-1:0] i_req,
  input  wire logic      [NUM_PERIPH-1:0] o_req_ready,
  input  wire pdma_ack_t [NUM_PERIPH-1:0] o_ack,
  input  wire logic      [NUM_PERIPH-1:0] i_ack_ready,
  input  wire logic                       i_abort_clear,
  input  wire logic                       o_irq_abort
);
  logic [3:0] rd_out_reg;
  logic [3:0] rd_out_next;
  // Reads in flight, retired by last beat
  always_comb
  begin
    rd_out_next = rd_out_reg + 4'(o_axi.arvalid && i_axi.arready)
                - 4'(i_axi.rvalid && o_axi.rready && i_axi.rlast);
  end
  always_ff @(posedge i_ref_clk or posedge i_reset)
    if (i_reset)
      rd_out_reg <= 4'h0;
    else
      rd_out_reg <= rd_out_next;
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (i_reset);
  sequence s_ar_wait;
    o_axi.arvalid && !i_axi.arready;
  endsequence
  chk_rd_limit: assert property (rd_out_reg <= MAX_RD_OUT)
    else $error("read limit exceeded");
  chk_ar_hold: assert property (s_ar_wait |=> o_axi.arvalid && $stable(o_axi.araddr))
    else $error("read address dropped");
  chk_fill_shape: assert property (o_axi.arvalid && o_axi.arid == FILL_ID |->
    o_axi.arlen == FILL_LEN && o_axi.araddr[4:0] == 5'h00)
    else $error("bad line fill");
  chk_slot_alt: assert property (o_inject_sec_ready || o_inject_nsec_ready |=>
    !o_inject_sec_ready && !o_inject_nsec_ready)
    else $error("manager slots adjacent");
  chk_one_insn: assert property (!(o_inject_sec_ready && o_inject_nsec_ready))
    else $error("two injections taken");
  chk_sec_first: assert property (o_inject_nsec_ready |-> !i_inject_sec.valid)
    else $error("secure port passed over");
  chk_req_full: assert property ($fell(o_req_ready[5]) |->
    $past(i_req[5].valid && i_req[5].kind != KIND_FLUSH))
    else $error("request ready fell without request");
  chk_ack_hold: assert property (o_ack[3].valid && !i_ack_ready[3] |=>
    o_ack[3].valid && $stable(o_ack[3].kind))
    else $error("ack dropped early");
  chk_abort_stick: assert property (o_irq_abort && !i_abort_clear |=> o_irq_abort)
    else $error("abort flag lost");
endmodule
bind pdma_engine pdma_checker i_pdma_checker (.i_ref_clk, .i_reset, .i_inject_sec,
  .o_inject_sec_ready, .o_inject_nsec_ready, .o_axi, .i_axi, .i_req, .o_req_ready, .o_ack,
  .i_ack_ready, .i_abort_clear, .o_irq_abort);

// ==== pdma_far_model.sv ====
// Far-side model: AXI memory slave and acknowledge taker
`timescale 1ns/1ps
module pdma_far_model
  import pdma_pkg::*;
(
  input  wire logic                  i_ref_clk,
  input  wire logic                  i_reset,
  input  wire pdma_axi_m_t           i_axi_m,
  output pdma_axi_s_t                o_axi_s,
  output logic      [NUM_PERIPH-1:0] o_ack_ready
);
  logic [7:0]  mem [0:511];
  logic [31:0] ra;
  logic [7:0]  n;
  logic        busy;
  initial
  begin
    foreach (mem[i]) mem[i] = 8'h00;
    // Wait on 3, ack 3 as burst, event 5, end
    {mem[256], mem[257], mem[258], mem[259], mem[260], mem[261]} = 48'h3003_3823_3405;
    // Load, no-op, store, end
    {mem[288], mem[289], mem[290]} = 24'h0401_08;
  end
  function automatic logic [63:0] beat(input logic [31:0] a);
    for (int k = 0; k < 8; k++) beat[8*k +: 8] = mem[a[8:0] + 9'(k)];
  endfunction
  always @(posedge i_ref_clk or posedge i_reset)
    if (i_reset)
    begin
      o_axi_s <= '0;
      o_ack_ready <= '0;
      busy <= 1'b0;
    end
    else
    begin
      o_ack_ready <= NUM_PERIPH'($urandom);
      o_axi_s.awready <= 1'b1;
      o_axi_s.wready <= 1'b1;
      o_axi_s.bvalid <= i_axi_m.awvalid && o_axi_s.awready;
      o_axi_s.bid <= i_axi_m.awid;
      if (!busy)
      begin
        o_axi_s.rvalid <= 1'b0;
        o_axi_s.rdata <= ~o_axi_s.rdata;
        o_axi_s.arready <= 1'($urandom);
        if (i_axi_m.arvalid && o_axi_s.arready)
        begin
          busy <= 1'b1;
          o_axi_s.arready <= 1'b0;
          ra <= i_axi_m.araddr;
          n <= i_axi_m.arlen;
          o_axi_s.rid <= i_axi_m.arid;
        end
      end
      else if (!o_axi_s.rvalid || i_axi_m.rready)
      begin
        if (o_axi_s.rvalid && o_axi_s.rlast)
        begin
          busy <= 1'b0;
          o_axi_s.rvalid <= 1'b0;
        end
        else
        begin
          o_axi_s.rvalid <= 1'b1;
          o_axi_s.rdata <= beat(ra);
          o_axi_s.rlast <= (n == 8'h00);
          ra <= ra + ADDR_STEP;
          n <= n - 8'h01;
        end
      end
    end
endmodule

// ==== tb_top.sv ====
// Testbench for the DMA instruction engine
`timescale 1ns/1ps
module tb_top
  import pdma_pkg::*;
;
  logic                       i_ref_clk;
  logic                       i_reset;
  pdma_inject_t               i_inject_sec;
  pdma_inject_t               i_inject_nsec;
  logic                       o_inject_sec_ready;
  logic                       o_inject_nsec_ready;
  pdma_axi_m_t                o_axi;
  pdma_axi_s_t                i_axi;
  pdma_req_t [NUM_PERIPH-1:0] i_req;
  logic      [NUM_PERIPH-1:0] o_req_ready;
  pdma_ack_t [NUM_PERIPH-1:0] o_ack;
  logic      [NUM_PERIPH-1:0] i_ack_ready;
  logic      [NUM_CHAN-1:0]   i_event_clear;
  logic                       i_abort_clear;
  logic      [1:0]            i_ecc_clear;
  logic      [1:0]            i_ecc_flip;
  logic                       o_irq_abort;
  logic      [NUM_CHAN-1:0]   o_irq_event;
  logic                       o_irq_ecc_single;
  logic                       o_irq_ecc_double;
  logic      [NUM_CHAN-1:0]   o_chan_active;
  logic                       o_pipe_stall;
  logic      [6:0]            exp_q[$];
  int                         error_cnt = 0;
  int                         check_count = 0;
  pdma_engine i_pdma_engine (.i_ref_clk, .i_reset, .i_inject_sec, .o_inject_sec_ready,
    .i_inject_nsec, .o_inject_nsec_ready, .o_axi, .i_axi, .i_req, .o_req_ready, .o_ack,
    .i_ack_ready, .i_event_clear, .i_abort_clear, .i_ecc_clear, .i_ecc_flip, .o_irq_abort,
    .o_irq_event, .o_irq_ecc_single, .o_irq_ecc_double, .o_chan_active, .o_pipe_stall);
  pdma_far_model i_pdma_far_model (.i_ref_clk, .i_reset, .i_axi_m(o_axi), .o_axi_s(i_axi),
    .o_ack_ready(i_ack_ready));
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic inject(input logic sec, input logic [47:0] insn);
    logic taken;
    taken = 1'b0;
    i_inject_sec = {sec, insn};
    i_inject_nsec = {!sec, insn};
    repeat (20)
    begin
      #1;
      taken = sec ? o_inject_sec_ready : o_inject_nsec_ready;
      if (taken)
        break;
      @(negedge i_ref_clk);
    end
    check("inject", 32'h1, 32'(taken));
    @(negedge i_ref_clk);
    i_inject_sec = {1'b0, ~insn};
    i_inject_nsec = {1'b0, ~insn};
  endtask
  initial
  begin
    i_ref_clk = 1'b0;
    forever #12.5 i_ref_clk = ~i_ref_clk;
  end
  // Each accepted ack takes the oldest expected one
  always @(posedge i_ref_clk)
    for (int p = 0; p < NUM_PERIPH; p++)
      if (!i_reset && o_ack[p].valid === 1'b1 && i_ack_ready[p] === 1'b1)
        check("ack", exp_q.size() ? 32'(exp_q.pop_front()) : 32'hFF, {5'(p), o_ack[p].kind});
  initial
  begin
    #500000;
    error_cnt++;
    finish_test();
  end
  initial
  begin
    i_reset = 1'b1;
    i_inject_sec = '0;
    i_inject_nsec = '0;
    i_req = '0;
    i_event_clear = 8'h00;
    i_abort_clear = 1'b0;
    i_ecc_clear = 2'h0;
    i_ecc_flip = 2'h0;
    void'($urandom(32'hdf01));
    repeat (5) @(negedge i_ref_clk);
    i_reset = 1'b0;
    check("req_ready", 32'h7FFF_FFFF, 32'(o_req_ready));
    check("active", 32'h0, 32'(o_chan_active));
    $display("test reset done");
    repeat (4)
    begin
      i_req[5] = {1'b1, 1'b0, 1'($urandom), 1'($urandom)};
      @(negedge i_ref_clk);
    end
    i_req[5] = {1'b0, 2'h3, 1'b1};
    check("req5_ready", 32'h0, 32'(o_req_ready[5]));
    $display("test request limit done");
    i_req[3] = {1'b1, KIND_BURST, 1'b1};
    @(negedge i_ref_clk);
    i_req[3] = {1'b0, 2'h2, 1'b0};
    exp_q.push_back({5'h03, KIND_BURST});
    inject(1'b1, 48'h0000_0100_00A0);
    check("active0", 32'h1, 32'(o_chan_active));
    repeat (400) if (o_irq_event[5] !== 1'b1) @(negedge i_ref_clk);
    check("event", 32'h20, 32'(o_irq_event));
    repeat (20) if (o_chan_active[0] !== 1'b0) @(negedge i_ref_clk);
    check("ended", 32'h0, 32'(o_chan_active));
    repeat (20) if (exp_q.size() != 0) @(negedge i_ref_clk);
    check("acks_left", 32'h0, 32'(exp_q.size()));
    i_event_clear = 8'hFF;
    @(negedge i_ref_clk);
    i_event_clear = 8'h00;
    check("event_clr", 32'h0, 32'(o_irq_event));
    $display("test channel program done");
    i_ecc_flip = 2'h1;
    inject(1'b1, 48'h0000_0120_01A0);
    repeat (100) if (o_irq_ecc_single !== 1'b1) @(negedge i_ref_clk);
    check("ecc1", 32'h1, 32'(o_irq_ecc_single));
    i_ecc_clear = 2'h1;
    i_ecc_flip = 2'h3;
    inject(1'b1, 48'h0000_0120_01A0);
    i_ecc_clear = 2'h0;
    repeat (100) if (o_irq_ecc_double !== 1'b1) @(negedge i_ref_clk);
    check("ecc2", 32'h1, 32'(o_irq_ecc_double));
    check("ecc1_clr", 32'h0, 32'(o_irq_ecc_single));
    $display("test ecc done");
    inject(1'b0, 48'h0000_0000_00FF);
    repeat (20) if (o_irq_abort !== 1'b1) @(negedge i_ref_clk);
    check("abort", 32'h1, 32'(o_irq_abort));
    $display("test abort done");
    finish_test();
  end
endmodule
